// [core/swl_loader.sv]
// serial wiper latch loader top: preset, shutdown, latch load and chain output
`timescale 1ns/1ps
module swl_loader #(
  parameter bit DUAL_CHANNEL = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       serial_in,
  input  wire logic       preset_mid_n,
  input  wire logic       shutdown_n,
  output logic            serial_chain_out,
  output logic            serial_chain_out_oe_n,
  output logic [7:0]      wiper_latch0,
  output logic [7:0]      wiper_latch1,
  output logic            a_terminal_open,
  output logic            wiper_to_b,
  output logic            load_strobe,
  output logic            loaded_channel,
  output logic            word_short
);

  typedef struct packed {
    swl_pkg::swl_state_t state;
    logic                link_run;
    logic                cs_s1;
    logic                cs_s2;
    logic                cs_s3;
    logic                pr_s1;
    logic                pr_s2;
    logic                sd_s1;
    logic                sd_s2;
    logic                tgl_s1;
    logic                tgl_s2;
    logic                tgl_s3;
    logic                bit_s1;
    logic                bit_s2;
    logic                chain_pend;
    logic                chain_latch;
    logic [3:0]          bit_cnt;
    logic [8:0]          word_cap;
    logic                sel;
    logic [7:0]          wiper0;
    logic [7:0]          wiper1;
    logic                a_open;
    logic                w2b;
    logic                od_out;
    logic                od_oe_n;
    logic                load_pulse;
    logic                last_ch;
    logic                short;
  } swl_core_st_t;

  swl_core_st_t st_reg;
  swl_core_st_t st_next;

  swl_link_if lnk ();

  swl_shifter u_shifter (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .serial_in (serial_in),
    .lnk       (lnk)
  );

  logic cs_rise;
  logic cs_fall;
  logic shift_seen;
  logic preset_on;
  logic shut_on;

  assign cs_rise    = st_reg.cs_s2 & ~st_reg.cs_s3;
  assign cs_fall    = ~st_reg.cs_s2 & st_reg.cs_s3;
  assign shift_seen = st_reg.tgl_s2 ^ st_reg.tgl_s3;
  assign preset_on  = ~st_reg.pr_s2;
  assign shut_on    = ~st_reg.sd_s2;

  always_comb begin
    st_next = st_reg;

    // pins from outside pass two flops before anything looks at them
    st_next.cs_s1  = cs_n;
    st_next.cs_s2  = st_reg.cs_s1;
    st_next.cs_s3  = st_reg.cs_s2;
    st_next.pr_s1  = preset_mid_n;
    st_next.pr_s2  = st_reg.pr_s1;
    st_next.sd_s1  = shutdown_n;
    st_next.sd_s2  = st_reg.sd_s1;
    st_next.tgl_s1 = lnk.shift_tgl;
    st_next.tgl_s2 = st_reg.tgl_s1;
    st_next.tgl_s3 = st_reg.tgl_s2;
    st_next.bit_s1 = lnk.chain_bit;
    st_next.bit_s2 = st_reg.bit_s1;

    st_next.link_run   = 1'h1;
    st_next.load_pulse = 1'h0;

    // chain bit is taken one cycle after its toggle, so both have settled
    st_next.chain_pend = shift_seen;
    if (st_reg.chain_pend) begin
      st_next.chain_latch = st_reg.bit_s2;
    end

    if (shift_seen && st_reg.bit_cnt != swl_pkg::SWL_CNT_MAX) begin
      st_next.bit_cnt = st_reg.bit_cnt + swl_pkg::SWL_CNT_ONE;
    end

    unique case (st_reg.state)
      swl_pkg::SWL_IDLE: begin
        if (cs_fall) begin
          st_next.state   = swl_pkg::SWL_FRAME;
          st_next.bit_cnt = swl_pkg::SWL_CNT_ZERO;
        end else if (cs_rise) begin
          st_next.state = swl_pkg::SWL_DECODE;
        end
      end
      swl_pkg::SWL_FRAME: begin
        if (cs_rise) begin
          st_next.state = swl_pkg::SWL_DECODE;
        end
      end
      swl_pkg::SWL_DECODE: begin
        // shifter is frozen now: chip select high stops every shift
        st_next.word_cap = lnk.word;
        st_next.state    = swl_pkg::SWL_LOAD;
      end
      swl_pkg::SWL_LOAD: begin
        st_next.sel = swl_pkg::swl_sel_of(DUAL_CHANNEL, st_reg.word_cap);
        if (swl_pkg::swl_sel_of(DUAL_CHANNEL, st_reg.word_cap) == swl_pkg::SWL_CH0) begin
          st_next.wiper0 = swl_pkg::swl_data_of(st_reg.word_cap);
        end else begin
          st_next.wiper1 = swl_pkg::swl_data_of(st_reg.word_cap);
        end
        st_next.load_pulse = 1'h1;
        st_next.last_ch    = swl_pkg::swl_sel_of(DUAL_CHANNEL, st_reg.word_cap);
        // a short frame still loads; the flag only tells software it happened
        st_next.short      = st_reg.bit_cnt < swl_pkg::swl_word_len(DUAL_CHANNEL);
        st_next.state      = swl_pkg::SWL_IDLE;
      end
    endcase

    // preset beats any load in flight and clears the chain latch
    if (preset_on) begin
      st_next.wiper0      = swl_pkg::SWL_MID_CODE;
      st_next.wiper1      = swl_pkg::SWL_MID_CODE;
      st_next.chain_latch = swl_pkg::SWL_PIN_LOW;
      st_next.load_pulse  = 1'h0;
      st_next.state       = swl_pkg::SWL_IDLE;
    end

    // shutdown steers the switches and releases the chain output, the latches are left as they are
    st_next.a_open  = shut_on;
    st_next.w2b     = shut_on;
    st_next.od_out  = swl_pkg::SWL_PIN_LOW;
    st_next.od_oe_n = shut_on ? swl_pkg::SWL_PIN_RELEASE
                              : st_next.chain_latch;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg             <= '0;
      st_reg.state       <= swl_pkg::SWL_IDLE;
      st_reg.cs_s1       <= 1'h1;
      st_reg.cs_s2       <= 1'h1;
      st_reg.cs_s3       <= 1'h1;
      st_reg.pr_s1       <= 1'h1;
      st_reg.pr_s2       <= 1'h1;
      st_reg.sd_s1       <= 1'h1;
      st_reg.sd_s2       <= 1'h1;
      st_reg.chain_latch <= swl_pkg::SWL_PIN_RELEASE;
      st_reg.wiper0      <= swl_pkg::SWL_MID_CODE;
      st_reg.wiper1      <= swl_pkg::SWL_MID_CODE;
      st_reg.od_out      <= swl_pkg::SWL_PIN_LOW;
      st_reg.od_oe_n     <= swl_pkg::SWL_PIN_RELEASE;
    end else begin
      st_reg <= st_next;
    end
  end

  // the shifter domain stays cleared while this side is in reset
  assign lnk.link_rst_n = st_reg.link_run;

  assign serial_chain_out      = st_reg.od_out;
  assign serial_chain_out_oe_n = st_reg.od_oe_n;
  assign wiper_latch0          = st_reg.wiper0;
  assign wiper_latch1          = st_reg.wiper1;
  assign a_terminal_open       = st_reg.a_open;
  assign wiper_to_b            = st_reg.w2b;
  assign load_strobe           = st_reg.load_pulse;
  assign loaded_channel        = st_reg.last_ch;
  assign word_short            = st_reg.short;

endmodule // swl_loader

// [core/swl_pkg.sv]
// constants, types and helpers shared by the serial wiper latch loader
package swl_pkg;

  localparam int          SWL_DATA_W      = 8;
  localparam int          SWL_WORD_W      = 9;
  localparam int          SWL_WORD_SINGLE = 8;
  localparam int          SWL_WORD_DUAL   = 9;
  localparam int          SWL_SEL_POS     = 8;
  localparam int          SWL_CHAIN_POS   = 7;
  localparam int          SWL_CNT_W       = 4;
  localparam logic [7:0]  SWL_MID_CODE    = 8'h80;
  localparam logic        SWL_CH0         = 1'h0;
  localparam logic        SWL_CH1         = 1'h1;
  localparam logic        SWL_PIN_RELEASE = 1'h1;
  localparam logic        SWL_PIN_LOW     = 1'h0;
  localparam logic [3:0]  SWL_CNT_MAX     = 4'hF;
  localparam logic [3:0]  SWL_CNT_ONE     = 4'h1;
  localparam logic [3:0]  SWL_CNT_ZERO    = 4'h0;

  typedef enum logic [3:0] {
    SWL_IDLE   = 4'h1,
    SWL_FRAME  = 4'h2,
    SWL_DECODE = 4'h4,
    SWL_LOAD   = 4'h8
  } swl_state_t;

  // number of bits in one serial word for the chosen variant
  function automatic logic [3:0] swl_word_len(input logic dual);
    swl_word_len = dual ? 4'(SWL_WORD_DUAL) : 4'(SWL_WORD_SINGLE);
  endfunction

  // channel addressed by a captured word; single variant always hits channel 0
  function automatic logic swl_sel_of(input logic dual, input logic [8:0] word);
    swl_sel_of = dual ? word[SWL_SEL_POS] : SWL_CH0;
  endfunction

  // data byte, always the last eight bits entered
  function automatic logic [7:0] swl_data_of(input logic [8:0] word);
    swl_data_of = word[SWL_DATA_W-1:0];
  endfunction

endpackage

// [core/swl_link_if.sv]
// carrier between the serial-clock shifter and the system-clock core
`timescale 1ns/1ps
interface swl_link_if;
  logic       link_rst_n;
  logic [8:0] word;
  logic       chain_bit;
  logic       shift_tgl;

  modport link (
    input  link_rst_n,
    output word,
    output chain_bit,
    output shift_tgl
  );

  modport core (
    output link_rst_n,
    input  word,
    input  chain_bit,
    input  shift_tgl
  );
endinterface

// [core/swl_shifter.sv]
// serial input shift register running on the host serial clock
`timescale 1ns/1ps
module swl_shifter (
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic serial_in,
  swl_link_if.link  lnk
);

  typedef struct packed {
    logic [8:0] sr;
    logic       chain;
    logic       tgl;
  } swl_shift_st_t;

  swl_shift_st_t st_reg;
  swl_shift_st_t st_next;

  always_comb begin
    st_next = st_reg;
    // edges while chip select is high leave everything alone
    if (!cs_n) begin
      // the bit that leaves the top falls away, so only the newest word stays
      st_next.sr    = {st_reg.sr[swl_pkg::SWL_WORD_W-2:0], serial_in};
      st_next.chain = st_reg.sr[swl_pkg::SWL_CHAIN_POS];
      st_next.tgl   = ~st_reg.tgl;
    end
  end

  // rising edge only; the core holds this domain in reset until it runs itself
  always_ff @(posedge sclk or negedge lnk.link_rst_n) begin
    if (!lnk.link_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lnk.word      = st_reg.sr;
  assign lnk.chain_bit = st_reg.chain;
  assign lnk.shift_tgl = st_reg.tgl;

endmodule // swl_shifter

// [dv/swl_host_model.sv]
// host serial master model driving the link pins of the loader
`timescale 1ns/1ps
module swl_host_model (
  output logic sclk,
  output logic cs_n,
  output logic serial_in
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // 32 ns serial clock, stands low outside shifting; exactly one word per call
  task automatic shift9(input logic [8:0] w);
    for (int i = 8; i >= 0; i--) begin
      serial_in = w[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
  endtask
  // single variant word: eight data bits, MSB first
  task automatic shift8(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      serial_in = w[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
  endtask
  task automatic open_frame();
    cs_n = 1'b0;
    #48;
  endtask
  // last clock rise lands well ahead of the chip select edge
  task automatic close_frame();
    #24 cs_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule // swl_host_model

// [dv/swl_loader_asserts.sv]
// port checks for the serial wiper latch loader
`timescale 1ns/1ps
module swl_loader_asserts #(
  parameter bit DUAL_CHANNEL = 1'b1
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       serial_in,
  input wire logic       preset_mid_n,
  input wire logic       shutdown_n,
  input wire logic       serial_chain_out,
  input wire logic       serial_chain_out_oe_n,
  input wire logic [7:0] wiper_latch0,
  input wire logic [7:0] wiper_latch1,
  input wire logic       a_terminal_open,
  input wire logic       wiper_to_b,
  input wire logic       load_strobe,
  input wire logic       loaded_channel,
  input wire logic       word_short
);
  logic [3:0] pr_hist;
  // preset pin is synced inside, so its effect trails by a few cycles
  always_ff @(posedge clk) pr_hist <= {pr_hist[2:0], preset_mid_n};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_shut_open: assert property (!shutdown_n [*5] |-> a_terminal_open && wiper_to_b)
    else $error("shutdown outputs wrong");
  chk_shut_chain: assert property (!shutdown_n [*5] |-> serial_chain_out_oe_n)
    else $error("chain driven in shutdown");
  chk_latch_hold: assert property (
    $changed(wiper_latch0) || $changed(wiper_latch1) |-> load_strobe || !(&pr_hist))
    else $error("latch moved without cause");
  chk_preset_mid: assert property (!preset_mid_n [*4] |->
    wiper_latch0 == swl_pkg::SWL_MID_CODE && wiper_latch1 == swl_pkg::SWL_MID_CODE)
    else $error("preset not mid-scale");
  chk_preset_noload: assert property (!preset_mid_n [*4] |-> !load_strobe)
    else $error("load during preset");
  chk_rise_loads: assert property ($rose(cs_n) && preset_mid_n |-> ##[2:7] load_strobe)
    else $error("no load after select rise");
  chk_load_cause: assert property (load_strobe |-> cs_n && !$past(cs_n, 7))
    else $error("load without select rise");
  chk_other_kept: assert property (load_strobe |->
    (loaded_channel ? $stable(wiper_latch0) : $stable(wiper_latch1)))
    else $error("other channel disturbed");
  chk_chain_pull: assert property (serial_chain_out == swl_pkg::SWL_PIN_LOW)
    else $error("chain output drives high");
  cover property (load_strobe && loaded_channel);
  cover property (load_strobe && !loaded_channel);
  cover property (!shutdown_n [*5]);
endmodule // swl_loader_asserts

bind swl_loader swl_loader_asserts #(.DUAL_CHANNEL(DUAL_CHANNEL)) u_chk (
  .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
  .preset_mid_n(preset_mid_n), .shutdown_n(shutdown_n), .serial_chain_out(serial_chain_out),
  .serial_chain_out_oe_n(serial_chain_out_oe_n), .wiper_latch0(wiper_latch0),
  .wiper_latch1(wiper_latch1), .a_terminal_open(a_terminal_open), .wiper_to_b(wiper_to_b),
  .load_strobe(load_strobe), .loaded_channel(loaded_channel), .word_short(word_short));

// [dv/test_serial_wiper_latch_loader.sv]
// self-checking bench for the serial wiper latch loader
`timescale 1ns/1ps
module test_serial_wiper_latch_loader;
  logic       clk, rstn, preset_mid_n, shutdown_n, sclk, cs_n, serial_in;
  logic       chain_val, oe_n, a_open, w2b, strobe, lch, wshort;
  logic [7:0] wl0, wl1, exp0, exp1;
  logic       sclk_s, cs_s_n, sin_s, s_strobe, s_lch, s_short;
  logic [7:0] s_wl0, s_wl1;
  int         err_total, samples_checked;

  always #5 clk = ~clk;
  swl_host_model u_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in));
  swl_loader #(.DUAL_CHANNEL(1'b1)) u_dut (
    .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .preset_mid_n(preset_mid_n), .shutdown_n(shutdown_n), .serial_chain_out(chain_val),
    .serial_chain_out_oe_n(oe_n), .wiper_latch0(wl0), .wiper_latch1(wl1),
    .a_terminal_open(a_open), .wiper_to_b(w2b), .load_strobe(strobe),
    .loaded_channel(lch), .word_short(wshort));
  // single-channel variant on its own host so its eight-bit words stay exact
  swl_host_model u_host_s (.sclk(sclk_s), .cs_n(cs_s_n), .serial_in(sin_s));
  swl_loader #(.DUAL_CHANNEL(1'b0)) u_dut_single (
    .clk(clk), .rstn(rstn), .sclk(sclk_s), .cs_n(cs_s_n), .serial_in(sin_s),
    .preset_mid_n(preset_mid_n), .shutdown_n(shutdown_n), .serial_chain_out(),
    .serial_chain_out_oe_n(), .wiper_latch0(s_wl0), .wiper_latch1(s_wl1),
    .a_terminal_open(), .wiper_to_b(), .load_strobe(s_strobe),
    .loaded_channel(s_lch), .word_short(s_short));

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // optional junk word ahead of the real one; chain tap then shows the word's first bit
  task automatic t_write(input logic [8:0] junk, input logic [8:0] w, input bit pre);
    int k;
    u_host.open_frame();
    if (pre) u_host.shift9(junk);
    u_host.shift9(w);
    if (pre) begin
      tick(8);
      cmp("chain_oe_n", {7'h0, w[8]}, {7'h0, oe_n});
    end
    u_host.close_frame();
    for (k = 0; k < 20 && strobe !== 1'b1; k++) tick(1);
    cmp("load_strobe", 8'h01, {7'h0, strobe});
    if (w[8]) exp1 = w[7:0];
    else exp0 = w[7:0];
    cmp("latch0", exp0, wl0);
    cmp("latch1", exp1, wl1);
    cmp("channel", {7'h0, w[8]}, {7'h0, lch});
    cmp("word_short", 8'h00, {7'h0, wshort});
    tick(2);
  endtask
  task automatic t_power_up();
    tick(4);
    cmp("latch0", 8'h80, wl0);
    cmp("latch1", 8'h80, wl1);
    cmp("single_latch0", 8'h80, s_wl0);
  endtask
  task automatic t_single(input logic [7:0] w);
    int k;
    u_host_s.open_frame();
    u_host_s.shift8(w);
    u_host_s.close_frame();
    for (k = 0; k < 20 && s_strobe !== 1'b1; k++) tick(1);
    cmp("single_strobe", 8'h01, {7'h0, s_strobe});
    cmp("single_latch0", w, s_wl0);
    cmp("single_latch1", 8'h80, s_wl1);
    cmp("single_channel", 8'h00, {7'h0, s_lch});
    cmp("single_short", 8'h00, {7'h0, s_short});
    tick(2);
  endtask
  task automatic t_cs_high();
    logic c;
    c = oe_n;
    u_host.shift9(9'h1AA);
    tick(8);
    cmp("chain_oe_n", {7'h0, c}, {7'h0, oe_n});
    cmp("latch0", exp0, wl0);
    cmp("latch1", exp1, wl1);
  endtask
  task automatic t_preset();
    preset_mid_n = 1'b0;
    tick(6);
    cmp("latch0", 8'h80, wl0);
    cmp("latch1", 8'h80, wl1);
    cmp("chain_oe_n", 8'h00, {7'h0, oe_n});
    cmp("chain_out", 8'h00, {7'h0, chain_val});
    cmp("single_latch0", 8'h80, s_wl0);
    preset_mid_n = 1'b1;
    tick(6);
    exp0 = 8'h80;
    exp1 = 8'h80;
  endtask
  task automatic t_shut();
    shutdown_n = 1'b0;
    tick(6);
    cmp("a_open", 8'h01, {7'h0, a_open});
    cmp("wiper_to_b", 8'h01, {7'h0, w2b});
    cmp("chain_oe_n", 8'h01, {7'h0, oe_n});
    shutdown_n = 1'b1;
    tick(6);
    cmp("a_open", 8'h00, {7'h0, a_open});
    cmp("latch0", exp0, wl0);
    cmp("latch1", exp1, wl1);
  endtask

  initial begin
    #100us;
    err_total++;
    print_verdict();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    preset_mid_n = 1'b1;
    shutdown_n = 1'b1;
    err_total = 0;
    samples_checked = 0;
    exp0 = 8'h80;
    exp1 = 8'h80;
    tick(20);
    rstn = 1'b1;
    t_power_up();
    t_single(8'hC5);
    t_write(9'h000, 9'h13C, 1'b0);
    t_write(9'h000, 9'h0A5, 1'b0);
    t_write(9'h1FF, 9'h0FF, 1'b1);
    t_write(9'h000, 9'h100, 1'b1);
    t_cs_high();
    t_preset();
    t_shut();
    t_write(9'h000, 9'h05A, 1'b0);
    t_shut();
    t_write(9'h000, 9'h1C3, 1'b0);
    t_single(8'h3A);
    print_verdict();
  end
endmodule // test_serial_wiper_latch_loader
